/* File: rtl/fws_pkg.sv */
/*
 * Shared constants and types for the fault and watchdog status bank.
 * Assumes an upstream serial front end that decodes register accesses.
 */
package fws_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_FAULT = 8'h0d;
  localparam logic [7:0] OFS_WDSTAT = 8'h0e;
  localparam logic [7:0] OFS_RAIL2 = 8'h0f;
  localparam logic [7:0] OFS_RAIL3 = 8'h10;
  localparam logic [7:0] OFS_MISC = 8'h11;
  localparam int NUM_REGS = 5;
  localparam logic [7:0] OFS_BASE = OFS_FAULT;
  // Fault status bit positions
  localparam int FB_CLK = 6;
  localparam int FB_SUP = 5;
  localparam int FB_RST = 4;
  localparam int FB_DEEP = 3;
  localparam int FB_PIN = 2;
  localparam int FB_THERM = 1;
  localparam int FB_INT = 0;
  localparam logic [7:0] FAULT_RC_MASK = 8'h7f;
  // Watchdog status bit positions
  localparam int WB_PIN = 5;
  localparam int WB_OPEN = 4;
  localparam int WB_ERR = 3;
  localparam int WB_KEY = 2;
  localparam int WB_EARLY = 1;
  localparam int WB_EXP = 0;
  localparam logic [7:0] WD_RC_MASK = 8'h07;
  // Setpoint and misc fields
  localparam int SP_W = 5;
  localparam logic [7:0] SP_MASK = 8'h1f;
  localparam int SEL_LSB = 6;
  localparam logic [7:0] MISC_MASK = 8'hc0;
  localparam logic [4:0] RAIL2_RST = 5'h00;
  localparam logic [4:0] RAIL3_RST = 5'h00;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [7:0] ZERO8 = 8'h00;
  // Setpoint encoding, for reference by the regulators
  localparam int SP_BASE_MV = 800;
  localparam int SP_STEP_MV = 50;

  typedef enum logic [1:0] {
    FWS_PIN_RSVD = 2'h0,
    FWS_PIN_WDOFF = 2'h1,
    FWS_PIN_SYNC = 2'h2,
    FWS_PIN_SEQOUT = 2'h3
  } fws_pin_sel_t;

  typedef struct packed {
    logic clk_err;
    logic regulator_ov;
    logic input_ov;
    logic reset_entered;
    logic deep_safe_state;
    logic reset_pin_short;
    logic reset_pulldown_fail;
    logic ground_loss;
    logic thermal_shutdown;
    logic otp_crc_fail;
    logic analog_self_test_fail;
  } fws_fault_ev_t;

  typedef struct packed {
    logic reset_pin_level;
    logic watchdog_window_open;
    logic watchdog_failure;
    logic key_mismatch;
    logic early_update;
    logic expired;
  } fws_wd_ev_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fws_req_t;

  function automatic logic [7:0] fws_sticky(input logic [7:0] cur,
      input logic [7:0] ev, input logic clr, input logic [7:0] mask);
    // Set wins over the clearing read
    fws_sticky = ((clr ? ZERO8 : cur) | ev) & mask;
  endfunction
endpackage

/* File: rtl/fws_sticky_reg.sv */
/*
 * One read-clear sticky status byte.
 * Assumes events are synchronous single-cycle or level inputs.
 */
`timescale 1ns/1ps
module fws_sticky_reg #(
  parameter logic [7:0] MASK = 8'hff
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] ev,
  input wire logic clr,
  output logic [7:0] flags_q
);
  import fws_pkg::*;
  logic [7:0] flags_d;

  always_comb begin
    flags_d = fws_sticky(flags_q, ev, clr, MASK);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= ZERO8;
    end else begin
      flags_q <= flags_d;
    end
  end
endmodule // fws_sticky_reg

/* File: rtl/fws_cfg_regs.sv */
/*
 * Writable setpoint and pin selector storage.
 * Assumes writes are single-cycle strobes from the access decoder.
 */
`timescale 1ns/1ps
module fws_cfg_regs (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic running,
  input wire fws_pkg::fws_req_t req,
  output logic [4:0] rail2_setpoint_code,
  output logic [4:0] rail3_setpoint_code,
  output fws_pkg::fws_pin_sel_t pin_sel_q
);
  import fws_pkg::*;
  logic [4:0] rail2_d;
  logic [4:0] rail3_d;
  fws_pin_sel_t sel_d;

  always_comb begin
    rail2_d = rail2_setpoint_code;
    rail3_d = rail3_setpoint_code;
    sel_d = pin_sel_q;
    if (req.wr) begin
      case (req.addr)
        OFS_RAIL2: rail2_d = req.wdata[SP_W-1:0];
        OFS_RAIL3: rail3_d = req.wdata[SP_W-1:0];
        // Selector is frozen once running
        OFS_MISC: if (!running) begin
          sel_d = fws_pin_sel_t'(req.wdata[SEL_LSB +: 2]);
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rail2_setpoint_code <= RAIL2_RST;
      rail3_setpoint_code <= RAIL3_RST;
      pin_sel_q <= fws_pin_sel_t'(SEL_RST);
    end else begin
      rail2_setpoint_code <= rail2_d;
      rail3_setpoint_code <= rail3_d;
      pin_sel_q <= sel_d;
    end
  end
endmodule // fws_cfg_regs

/* File: rtl/fws_status_bank.sv */
/*
 * Fault and watchdog status register bank with rail setpoints and
 * multi-function pin selector, at offsets 0x0d to 0x11.
 * Assumes the serial front end presents decoded single-cycle read and
 * write strobes on sys_clk and samples rdata the cycle after a read.
 */
// What this block does
// - Clock monitor error sets fault bit 6, cleared by reading.
// - Regulator or input overvoltage sets fault bit 5, cleared by read.
// - Entry to reset state sets fault bit 4 until read.
// - Deep-safe entry sets fault bit 3 until read.
// - Reset pin short, pull-down fail or ground loss latch bit 2.
// - Thermal shutdown latches fault bit 2's neighbour, bit 1.
// - OTP CRC or analog self-test failure sets fault bit 0.
// - Watchdog status bit 5 shows live reset output pin level.
// - Watchdog status bit 4 shows live open-window state.
// - Bit 3 shows failures reached threshold; key mismatches excluded.
// - Wrong key write sets read-clear watchdog status bit 2.
// - Key write in closed window sets read-clear bit 1.
// - Window passing without key write sets read-clear bit 0.
// - Rail 2 code bits 4:0, 0.8V plus 50mV per step.
// - Rail 3 code, same encoding as rail 2.
// - Pin selector bits 7:6: reserved, wd-disable, sync, sequencer.
// - Reserved bits are read-only and read as zero.
`timescale 1ns/1ps
module fws_status_bank (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire fws_pkg::fws_req_t req,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  input wire logic running,
  input wire fws_pkg::fws_fault_ev_t fault_ev,
  input wire fws_pkg::fws_wd_ev_t wd_ev,
  output logic [4:0] rail2_setpoint_code,
  output logic [4:0] rail3_setpoint_code,
  output fws_pkg::fws_pin_sel_t pin_sel,
  output logic watchdog_disable_input_sel,
  output logic clock_sync_input_sel,
  output logic sequencer_output_sel
);
  import fws_pkg::*;

  // ****************************************************************
  // Event gathering
  // ****************************************************************
  logic [7:0] fault_ev_v;
  logic [7:0] wd_ev_v;
  logic [7:0] fault_q;
  logic [7:0] wd_q;
  logic rd_fault;
  logic rd_wd;
  logic deep_q;
  logic deep_d;

  // Deep-safe is a level; flag only its entry
  always_comb begin
    deep_d = fault_ev.deep_safe_state;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      deep_q <= 1'b0;
    end else begin
      deep_q <= deep_d;
    end
  end

  always_comb begin
    fault_ev_v = ZERO8;
    fault_ev_v[FB_CLK] = fault_ev.clk_err;
    fault_ev_v[FB_SUP] = fault_ev.regulator_ov | fault_ev.input_ov;
    fault_ev_v[FB_RST] = fault_ev.reset_entered;
    fault_ev_v[FB_DEEP] = fault_ev.deep_safe_state & ~deep_q;
    fault_ev_v[FB_PIN] = fault_ev.reset_pin_short |
        fault_ev.reset_pulldown_fail | fault_ev.ground_loss;
    fault_ev_v[FB_THERM] = fault_ev.thermal_shutdown;
    fault_ev_v[FB_INT] = fault_ev.otp_crc_fail |
        fault_ev.analog_self_test_fail;
    wd_ev_v = ZERO8;
    wd_ev_v[WB_KEY] = wd_ev.key_mismatch;
    wd_ev_v[WB_EARLY] = wd_ev.early_update;
    wd_ev_v[WB_EXP] = wd_ev.expired;
    rd_fault = req.rd && (req.addr == OFS_FAULT);
    rd_wd = req.rd && (req.addr == OFS_WDSTAT);
  end

  // ****************************************************************
  // Sticky flags
  // ****************************************************************
  fws_sticky_reg #(.MASK(FAULT_RC_MASK)) u_fault (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ev(fault_ev_v),
    .clr(rd_fault),
    .flags_q(fault_q)
  );

  fws_sticky_reg #(.MASK(WD_RC_MASK)) u_wd (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ev(wd_ev_v),
    .clr(rd_wd),
    .flags_q(wd_q)
  );

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  fws_cfg_regs u_cfg (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .running(running),
    .req(req),
    .rail2_setpoint_code(rail2_setpoint_code),
    .rail3_setpoint_code(rail3_setpoint_code),
    .pin_sel_q(pin_sel)
  );

  always_comb begin
    watchdog_disable_input_sel = (pin_sel == FWS_PIN_WDOFF);
    clock_sync_input_sel = (pin_sel == FWS_PIN_SYNC);
    sequencer_output_sel = (pin_sel == FWS_PIN_SEQOUT);
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [7:0] rdata_d;
  logic rvalid_d;
  logic [7:0] wd_view;

  always_comb begin
    wd_view = wd_q;
    wd_view[WB_PIN] = wd_ev.reset_pin_level;
    wd_view[WB_OPEN] = wd_ev.watchdog_window_open;
    // Failure count already applied upstream per threshold bit
    wd_view[WB_ERR] = wd_ev.watchdog_failure;
    rdata_d = ZERO8;
    rvalid_d = req.rd;
    if (req.rd) begin
      case (req.addr)
        OFS_FAULT: rdata_d = fault_q & FAULT_RC_MASK;
        OFS_WDSTAT: rdata_d = wd_view;
        OFS_RAIL2: rdata_d = {3'h0, rail2_setpoint_code};
        OFS_RAIL3: rdata_d = {3'h0, rail3_setpoint_code};
        OFS_MISC: rdata_d = {pin_sel, 6'h00};
        default: rdata_d = ZERO8;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= ZERO8;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end
endmodule // fws_status_bank

/* File: bench/fws_status_bank_sva.sv */
/* Port checker for the status bank.
   Bound to every fws_status_bank; sees only its ports. */
`timescale 1ns/1ps
module fws_status_bank_sva (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire fws_pkg::fws_req_t req,
  input wire logic [7:0] rdata_q,
  input wire logic rvalid_q,
  input wire logic running,
  input wire fws_pkg::fws_fault_ev_t fault_ev,
  input wire fws_pkg::fws_wd_ev_t wd_ev,
  input wire logic [4:0] rail2_setpoint_code,
  input wire logic [4:0] rail3_setpoint_code,
  input wire fws_pkg::fws_pin_sel_t pin_sel,
  input wire logic watchdog_disable_input_sel,
  input wire logic clock_sync_input_sel,
  input wire logic sequencer_output_sel
);
  import fws_pkg::*;
  // ***
  // Properties
  // ***
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic rd_f, rd_w, wr2, wr3;
  assign rd_f = req.rd && req.addr == OFS_FAULT;
  assign rd_w = req.rd && req.addr == OFS_WDSTAT;
  assign wr2 = req.wr && req.addr == OFS_RAIL2;
  assign wr3 = req.wr && req.addr == OFS_RAIL3;
  pin_live_a: assert property (rd_w |=>
    rdata_q[WB_PIN] == $past(wd_ev.reset_pin_level)) else $error("pin");
  watchdog_failure_flag_a: assert property (rd_w |=>
    rdata_q[WB_ERR] == $past(wd_ev.watchdog_failure)) else $error("err");
  fault_rsvd_a: assert property (rd_f |=> !rdata_q[7])
    else $error("rsvd");
  rail2_wr_a: assert property (wr2 |=>
    rail2_setpoint_code == $past(req.wdata[4:0])) else $error("rail2");
  rail3_wr_a: assert property (wr3 |=>
    rail3_setpoint_code == $past(req.wdata[4:0])) else $error("rail3");
  sel_lock_a: assert property (running |=> $stable(pin_sel))
    else $error("lock");
  sel_decode_a: assert property (
    watchdog_disable_input_sel == (pin_sel == FWS_PIN_WDOFF) &&
    clock_sync_input_sel == (pin_sel == FWS_PIN_SYNC) &&
    sequencer_output_sel == (pin_sel == FWS_PIN_SEQOUT)) else $error("dec");
  therm_keep_a: assert property (
    (rd_f && fault_ev.thermal_shutdown) ##1 !rd_f ##1 rd_f |=>
    rdata_q[FB_THERM]) else $error("keep");
  key_flag_a: assert property (
    wd_ev.key_mismatch ##1 !rd_w ##1 rd_w |=> rdata_q[WB_KEY])
    else $error("key");
  early_flag_a: assert property (
    wd_ev.early_update ##1 !rd_w ##1 rd_w |=> rdata_q[WB_EARLY])
    else $error("early");
  exp_flag_a: assert property (
    wd_ev.expired ##1 !rd_w ##1 rd_w |=> rdata_q[WB_EXP])
    else $error("expired");
  clk_clear_a: assert property ((rd_f && !fault_ev.clk_err)
    ##1 !fault_ev.clk_err ##1 rd_f |=> !rdata_q[FB_CLK]) else $error("clr");
endmodule // fws_status_bank_sva

bind fws_status_bank fws_status_bank_sva chk_u (.sys_clk, .sys_rst, .req,
  .rdata_q, .rvalid_q, .running, .fault_ev, .wd_ev, .rail2_setpoint_code,
  .rail3_setpoint_code, .pin_sel, .watchdog_disable_input_sel,
  .clock_sync_input_sel, .sequencer_output_sel);

/* File: bench/fws_host_model.sv */
/* Host model issuing single-cycle register accesses.
   Expects the bank's read answer one cycle after the read edge. */
`timescale 1ns/1ps
module fws_host_model (
  input wire logic sys_clk,
  input wire logic [7:0] rdata_q,
  input wire logic rvalid_q,
  output fws_pkg::fws_req_t req
);
  import fws_pkg::*;
  // ***
  // Access tasks
  // ***
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, a, v};
    @(posedge sys_clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    req <= '0;
    #1;
    // Missing answer turns into unknown so no compare can pass
    v = rvalid_q ? rdata_q : 8'hxx;
  endtask
endmodule // fws_host_model

/* File: bench/fws_status_bank_tb.sv */
/* Self-checking bench for the status bank.
   Assumes the host model on the access port and a 25 MHz clock. */
`timescale 1ns/1ps
module fws_status_bank_tb;
  import fws_pkg::*;
  // ***
  // Signals and instances
  // ***
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic running = 1'b0;
  fws_req_t req;
  fws_fault_ev_t fault_ev = '0;
  fws_wd_ev_t wd_ev = '0;
  logic [7:0] rdata_q, d;
  logic rvalid_q, wdis, sync, seqo;
  logic [4:0] r2, r3;
  fws_pin_sel_t sel;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int fbit[11] = '{0, 0, 1, 2, 2, 2, 3, 4, 5, 5, 6};
  fws_host_model host_u (.sys_clk, .rdata_q, .rvalid_q, .req);
  fws_status_bank dut_u (.sys_clk, .sys_rst, .req, .rdata_q, .rvalid_q,
    .running, .fault_ev, .wd_ev, .rail2_setpoint_code(r2),
    .rail3_setpoint_code(r3), .pin_sel(sel),
    .watchdog_disable_input_sel(wdis), .clock_sync_input_sel(sync),
    .sequencer_output_sel(seqo));
  initial forever #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic t_reset();
    host_u.wr(8'h12, 8'hff);
    for (int a = 13; a < 19; a++) begin
      host_u.rd(8'(a), d);
      chk(d, 8'h00);
    end
  endtask
  task automatic t_fault();
    for (int i = 0; i < 11; i++) begin
      @(posedge sys_clk);
      fault_ev <= fws_fault_ev_t'(11'h001 << i);
      @(posedge sys_clk);
      fault_ev <= '0;
      host_u.rd(OFS_FAULT, d);
      if (i < 6) chk(d, 8'(1 << fbit[i]));
      else chk(d, 8'(1 << fbit[i]));
      host_u.rd(OFS_FAULT, d);
      if (i < 6) chk(d, 8'h00);
      else chk(d, 8'h00);
    end
  endtask
  task automatic t_wd();
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      wd_ev <= fws_wd_ev_t'(6'h01 << i);
      @(posedge sys_clk);
      if (i < 3) wd_ev <= '0;
      host_u.rd(OFS_WDSTAT, d);
      if (i < 3) chk(d, 8'(1 << i));
      else chk(d, 8'(1 << i));
      @(posedge sys_clk);
      wd_ev <= '0;
      host_u.rd(OFS_WDSTAT, d);
      chk(d, 8'h00);
    end
  endtask
  task automatic t_same();
    // Event lands on the very edge that takes the clearing read
    fork
      host_u.rd(OFS_FAULT, d);
      begin
        @(posedge sys_clk);
        fault_ev.thermal_shutdown <= 1'b1;
        @(posedge sys_clk);
        fault_ev <= '0;
      end
    join
    chk(d, 8'h00);
    host_u.rd(OFS_FAULT, d);
    chk(d, 8'h02);
  endtask
  task automatic t_rail();
    logic [7:0] v;
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'h0a : 8'hff;
      host_u.wr(OFS_RAIL2, v);
      host_u.wr(OFS_RAIL3, ~v);
      #1;
      chk({3'h0, r2}, v & SP_MASK);
      chk({3'h0, r3}, ~v & SP_MASK);
      host_u.rd(OFS_RAIL2, d);
      chk(d, v & SP_MASK);
      host_u.rd(OFS_RAIL3, d);
      chk(d, ~v & SP_MASK);
    end
  endtask
  task automatic t_sel();
    logic [7:0] e;
    for (int i = 0; i < 4; i++) begin
      host_u.wr(OFS_MISC, 8'(i << SEL_LSB) | 8'h3f);
      host_u.rd(OFS_MISC, d);
      chk(d, 8'(i << SEL_LSB));
      e = {5'h0, i == 1, i == 2, i == 3};
      chk({5'h0, wdis, sync, seqo}, e);
    end
    @(posedge sys_clk);
    running <= 1'b1;
    host_u.wr(OFS_MISC, 8'h40);
    host_u.rd(OFS_MISC, d);
    chk(d, 8'hc0);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_fault();
    t_wd();
    t_same();
    t_rail();
    t_sel();
    // Mid-run reset must bring every register back to its reset value
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    running <= 1'b0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    complete_run();
  end
endmodule // fws_status_bank_tb
